// file: include/sdadc_consts.vh
// constants for the bitstream converter control block
// assumes inclusion by sdadc_core only; sdadc_buf2 does not include it
`ifndef SDADC_CONSTS_VH
`define SDADC_CONSTS_VH
`define SDADC_TICK_PERIOD 217
`define SDADC_PRESCALE 1
`define SDADC_UPDATE_DIV 4
`define SDADC_OSR 256
`define SDADC_RES_W 8
`define SDADC_TICK_W 8
`define SDADC_DIV_W 8
`define SDADC_CNT_MAX 8'hff
`define SDADC_ZERO8 8'h00
`define SDADC_ONE8 8'h01
`endif

// file: sim/sdadc_chk_sva.sv
// assertions on the converter core ports
// bound onto sdadc_core after the module
`timescale 1ns/100ps
module sdadc_chk #(
  parameter TICK_PERIOD = 217,
  parameter PRESCALE = 1,
  parameter UPDATE_DIV = 4
) (
  input wire mclk,
  input wire rstn,
  input wire quant_in,
  input wire fb_out,
  input wire [7:0] conversion_result,
  input wire result_valid,
  input wire result_ready,
  input wire update_strobe
);
  integer gap_r;
  reg seen_r;
  always @(posedge mclk)
  begin
    gap_r <= update_strobe ? 0 : gap_r + 1;
    seen_r <= rstn && (seen_r || update_strobe);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_fb_inv: assert property (update_strobe |=> fb_out == !$past(quant_in))
    else $error("feedback wrong");
  a_fb_hold: assert property (!update_strobe |=> $stable(fb_out))
    else $error("feedback moved");
  a_tick_gap: assert property (update_strobe && seen_r |->
    gap_r == TICK_PERIOD * PRESCALE * UPDATE_DIV - 1) else $error("update spacing");
  a_tick_pulse: assert property (update_strobe |=> !update_strobe)
    else $error("update pulse");
  a_push_time: assert property ($rose(result_valid) |-> $past(update_strobe, 2))
    else $error("push timing");
  a_word_hold: assert property (result_valid && !result_ready |=>
    result_valid && $stable(conversion_result)) else $error("word changed");
  a_word_pop: assert property ($fell(result_valid) |-> $past(result_ready))
    else $error("word lost");
  a_reset_clr: assert property (disable iff (1'b0) !rstn |=>
    !fb_out && !result_valid && conversion_result == 8'h00) else $error("reset state");
endmodule // sdadc_chk
bind sdadc_core sdadc_chk #(.TICK_PERIOD(TICK_PERIOD), .PRESCALE(PRESCALE),
  .UPDATE_DIV(UPDATE_DIV)) chk (.*);

// file: sim/sdadc_core_tb.sv
// bench for the converter core
// assumes the rc model and the bound checker
`timescale 1ns/100ps
module sdadc_core_tb;
  reg mclk = 1'b0;
  reg rstn = 1'b0;
  reg rdy = 1'b0;
  reg [8:0] lvl = 9'h000;
  reg [67:0] rows = {9'h040, 8'h40, 9'h080, 8'h80, 9'h100, 8'hff, 9'h000, 8'h00};
  reg [7:0] w;
  wire q, fb, vld, stb;
  wire [7:0] res;
  integer n_errors = 0, num_checks = 0, i;
  sdadc_core #(.TICK_PERIOD(3), .PRESCALE(2), .UPDATE_DIV(2)) dut (.mclk(mclk),
    .rstn(rstn), .quant_in(q), .fb_out(fb), .conversion_result(res),
    .result_valid(vld), .result_ready(rdy), .update_strobe(stb));
  sdadc_rc rc (.mclk(mclk), .fb_out(fb), .update_strobe(stb), .lvl(lvl), .quant_in(q));
  initial forever #50 mclk = ~mclk;
  task check(input [7:0] seen, input [7:0] want);
  begin
    num_checks = num_checks + 1;
    if (seen !== want)
    begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: %h not %h", $time, seen, want);
    end
  end
  endtask
  task test_done;
  begin
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task get_word;
    integer k;
  begin
    for (k = 0; vld !== 1'b1; k = k + 1)
    begin
      if (k == 4000)
      begin
        check(8'h00, 8'h01);
        test_done;
      end
      @(posedge mclk);
      #1;
    end
    w = res;
    rdy = 1'b1;
    @(posedge mclk);
    #1;
    rdy = 1'b0;
    @(posedge mclk);
    #1;
  end
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    #1;
    check({6'h00, fb, vld}, 8'h00);
    check(res, 8'h00);
    rstn = 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      lvl = rows[i*17+8 +: 9];
      repeat (3) get_word;
      check(w, rows[i*17 +: 8]);
    end
    repeat (10752) @(posedge mclk);
    #1;
    repeat (2) get_word;
    check(w, 8'h40);
    check({7'h00, vld}, 8'h00);
    rstn = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check({6'h00, fb, vld}, 8'h00);
    check(res, 8'h00);
    rstn = 1'b1;
    get_word;
    check(w, 8'h40);
    test_done;
  end
endmodule // sdadc_core_tb

// file: sim/sdadc_rc.sv
// rc integrator model on quant_in and fb_out
// assumes lvl as input voltage, 256 is full supply
`timescale 1ns/100ps
module sdadc_rc (
  input wire mclk,
  input wire fb_out,
  input wire update_strobe,
  input wire [8:0] lvl,
  output wire quant_in
);
  integer v = 0;
  reg upd_d = 1'b0;
  assign quant_in = v > 0;
  always @(posedge mclk)
  begin
    upd_d <= update_strobe;
    if (upd_d)
      v <= v + lvl - (fb_out ? 0 : 256);
  end
endmodule // sdadc_rc

// file: src/sdadc_buf2.v
// two-entry valid/ready buffer for conversion results
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
module sdadc_buf2 #(
  parameter W = 8
) (
  input wire mclk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] d0_r;
  reg [W-1:0] d1_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = d0_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      cnt_r <= 2'd0;
      d0_r <= {W{1'b0}};
      d1_r <= {W{1'b0}};
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (cnt_r == 2'd0)
            d0_r <= in_data;
          else
            d1_r <= in_data;
          cnt_r <= cnt_r + 2'd1;
        end
        2'b01:
        begin
          d0_r <= d1_r;
          cnt_r <= cnt_r - 2'd1;
        end
        2'b11:
        begin
          if (cnt_r == 2'd1)
            d0_r <= in_data;
          else
          begin
            d0_r <= d1_r;
            d1_r <= in_data;
          end
        end
        default:
        begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end
endmodule // sdadc_buf2

// file: src/sdadc_core.v
// first-order bitstream converter: quantizer pin, feedback pin, count-of-ones decimator
// assumes an external rc integrator between fb_out and quant_in, one clock mclk
//
// Contract
// - quantizer pin read as one logic bit
// - feedback pin charges or discharges capacitor
// - feedback drives inverse of sampled quantizer
// - updates strictly on uniform tick strobes
// - high sample increments ones accumulator
// - pass counter increments every update
// - counter wrap copies accumulator to result
// - accumulator cleared each 256 update block
// - result linear, 00h zero, ffh full
// - tick from clock over period and prescaler
// - one update per update_divider ticks
// - decimation never exceeds oversampling ratio
// - plain first-order count of ones
`timescale 1ns/100ps
`include "sdadc_consts.vh"
module sdadc_core #(
  parameter TICK_PERIOD = `SDADC_TICK_PERIOD,
  parameter PRESCALE = `SDADC_PRESCALE,
  parameter UPDATE_DIV = `SDADC_UPDATE_DIV
) (
  input wire mclk,
  input wire rstn,
  input wire quant_in,
  output wire fb_out,
  output wire [`SDADC_RES_W-1:0] conversion_result,
  output wire result_valid,
  input wire result_ready,
  output wire update_strobe
);
  reg [`SDADC_TICK_W-1:0] tick_cnt_r;
  reg [`SDADC_DIV_W-1:0] pre_cnt_r;
  reg [`SDADC_DIV_W-1:0] div_cnt_r;
  reg [`SDADC_RES_W-1:0] pass_counter_r;
  reg [`SDADC_RES_W:0] ones_accumulator_r;
  reg [`SDADC_RES_W-1:0] result_r;
  reg fb_r;
  reg dump_r;
  reg [`SDADC_RES_W:0] acc_nxt;
  wire tick_end;
  wire pre_end;
  wire tick;
  wire div_end;
  wire update;
  wire wrap;
  wire [`SDADC_RES_W-1:0] dumped;
  assign tick_end = (tick_cnt_r == TICK_PERIOD[`SDADC_TICK_W-1:0] - `SDADC_ONE8);
  assign pre_end = (pre_cnt_r == PRESCALE[`SDADC_DIV_W-1:0] - `SDADC_ONE8);
  assign tick = tick_end && pre_end;
  assign div_end = (div_cnt_r == UPDATE_DIV[`SDADC_DIV_W-1:0] - `SDADC_ONE8);
  assign update = tick && div_end;
  assign wrap = update && (pass_counter_r == `SDADC_CNT_MAX);
  assign update_strobe = update;
  assign fb_out = fb_r;
  // a full 256 ones saturates to ffh so the scale stays 00h..ffh
  assign dumped = acc_nxt[`SDADC_RES_W] ? `SDADC_CNT_MAX :
                  acc_nxt[`SDADC_RES_W-1:0];
  always @*
  begin
    acc_nxt = ones_accumulator_r;
    if (update)
    begin
      if (quant_in)
        acc_nxt = ones_accumulator_r + {`SDADC_ZERO8, 1'b1};
    end
  end
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      tick_cnt_r <= `SDADC_ZERO8;
      pre_cnt_r <= `SDADC_ZERO8;
      div_cnt_r <= `SDADC_ZERO8;
      pass_counter_r <= `SDADC_ZERO8;
      ones_accumulator_r <= {1'b0, `SDADC_ZERO8};
      result_r <= `SDADC_ZERO8;
      fb_r <= 1'b0;
      dump_r <= 1'b0;
    end
    else
    begin
      if (tick_end)
      begin
        tick_cnt_r <= `SDADC_ZERO8;
        pre_cnt_r <= pre_end ? `SDADC_ZERO8 : pre_cnt_r + `SDADC_ONE8;
      end
      else
        tick_cnt_r <= tick_cnt_r + `SDADC_ONE8;
      if (tick)
        div_cnt_r <= div_end ? `SDADC_ZERO8 : div_cnt_r + `SDADC_ONE8;
      dump_r <= 1'b0;
      if (update)
      begin
        fb_r <= ~quant_in;
        pass_counter_r <= pass_counter_r + `SDADC_ONE8;
      end
      if (wrap)
      begin
        result_r <= dumped;
        ones_accumulator_r <= {1'b0, `SDADC_ZERO8};
        dump_r <= 1'b1;
      end
      else
        ones_accumulator_r <= acc_nxt;
    end
  end
  sdadc_buf2 #(
    .W(`SDADC_RES_W)
  ) u_buf (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(dump_r),
    .in_ready(),
    .in_data(result_r),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(conversion_result)
  );
endmodule // sdadc_core
